/* File: hw/dps_pkg.sv */
// Package for the dual-port SRAM port controller: pins, commands, timing.
// Assumes a 100 MHz system clock and a device port of 128K x 8.
package dps_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Timing in ns and in 10 ns clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_NS      = 10;
    localparam int T_EW_NS     = 15;
    localparam int T_WP_NS     = 15;
    localparam int T_WZ_NS     = 10;
    localparam int T_DW_NS     = 15;
    localparam int T_RC_NS     = 20;
    localparam int T_HZ_NS     = 10;
    localparam int T_SWRD_NS   = 5;
    localparam int T_SOP_NS    = 10;
    localparam int T_WP_OE_NS  = (T_WP_NS > T_WZ_NS + T_DW_NS) ?
                                 T_WP_NS : T_WZ_NS + T_DW_NS;
    localparam int WP_CYC      = (T_WP_OE_NS + CLK_NS - 1) / CLK_NS;
    // Read data crosses two synchroniser stages, so the wait grows by two.
    localparam int RD_CYC      = (T_RC_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int HZ_CYC      = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int SWRD_CYC    = (T_SWRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SOP_CYC     = (T_SOP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_MEM_RD = 2'h0,
        CMD_MEM_WR = 2'h1,
        CMD_SEM_RD = 2'h2,
        CMD_SEM_WR = 2'h3
    } dps_cmd_t;

    typedef struct packed {
        dps_cmd_t            cmd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } dps_req_t;

    typedef struct packed {
        logic                array_sel_n;
        logic                flag_select_n;
        logic                write_n;
        logic                out_en_n;
        logic [ADDR_W-1:0]   addr;
    } dps_pins_t;

endpackage

/* File: hw/dps_ctrl.sv */
// Host-side controller for one port of an asynchronous dual-port SRAM.
// Assumes the device pins are wired straight to this module's ports and
// that data pins are resolved by the testbench from data_oe_o.
`timescale 1ns/1ns

module dps_ctrl
    import dps_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // User request port
    input  wire logic              req_valid_i,
    input  wire dps_req_t          req_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_data_o,
    // Device port pins
    output dps_pins_t              pins_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    input  wire logic [DATA_W-1:0] data_i
);

    // ------------------------------------------------------------------
    // Input synchroniser and state
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_WRITE = 6'h04,
        ST_HOLD  = 6'h08,
        ST_READ  = 6'h10,
        ST_GAP   = 6'h20
    } dps_state_t;

    logic [DATA_W-1:0] sync1_reg;
    logic [DATA_W-1:0] sync2_reg;
    dps_state_t        state_reg,  state_next;
    logic [CNT_W-1:0]  cnt_reg,    cnt_next;
    dps_req_t          cur_reg,    cur_next;
    dps_pins_t         pins_reg,   pins_next;
    logic [DATA_W-1:0] dout_reg,   dout_next;
    logic              doe_reg,    doe_next;
    logic              ready_reg,  ready_next;
    logic              rspv_reg,   rspv_next;
    logic [DATA_W-1:0] rspd_reg,   rspd_next;
    logic              is_sem;

    // Counts share one counter, so it must hold the largest of them.
    if (WP_CYC >= (1 << CNT_W) || RD_CYC >= (1 << CNT_W)) begin : g_cnt_chk
        $error("dps_ctrl: counter too narrow for timing");
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= data_i;
            sync2_reg <= sync1_reg;
        end
    end

    assign is_sem = cur_reg.cmd[1];

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cur_next   = cur_reg;
        pins_next  = pins_reg;
        dout_next  = dout_reg;
        doe_next   = doe_reg;
        ready_next = 1'b0;
        rspv_next  = 1'b0;
        rspd_next  = rspd_reg;
        case (state_reg)
            ST_IDLE: begin
                ready_next = 1'b1;
                if (req_valid_i && ready_reg) begin
                    ready_next = 1'b0;
                    cur_next   = req_i;
                    // Address moves only with every strobe high.
                    pins_next.addr = req_i.addr;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Select and strobe drop together; device output stays off only for a write.
                pins_next.array_sel_n   = is_sem;
                pins_next.flag_select_n = !is_sem;
                cnt_next = '0;
                if (cur_reg.cmd[0]) begin
                    // Output drive stays off through the write, which keeps
                    // the device off the data lines while we drive them.
                    pins_next.out_en_n = 1'b1;
                    pins_next.write_n  = 1'b0;
                    dout_next = cur_reg.wdata;
                    doe_next  = 1'b1;
                    state_next = ST_WRITE;
                end else begin
                    pins_next.out_en_n = 1'b0;
                    state_next = ST_READ;
                end
            end
            ST_WRITE: begin
                cnt_next = cnt_reg + 1'b1;
                // Pulse covers turn-off plus setup, and holds the select.
                if (cnt_reg == CNT_W'(WP_CYC - 1)) begin
                    pins_next.write_n = 1'b1;
                    cnt_next   = '0;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data held one cycle past the strobe edge.
                doe_next = 1'b0;
                pins_next.array_sel_n   = 1'b1;
                pins_next.flag_select_n = 1'b1;
                cnt_next   = '0;
                state_next = ST_GAP;
            end
            ST_READ: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(RD_CYC - 1)) begin
                    rspv_next = 1'b1;
                    rspd_next = sync2_reg;
                    pins_next.out_en_n      = 1'b1;
                    pins_next.array_sel_n   = 1'b1;
                    pins_next.flag_select_n = 1'b1;
                    cnt_next   = '0;
                    state_next = ST_GAP;
                end
            end
            ST_GAP: begin
                // Gap covers flag update, write-to-read and device turn-off.
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(HZ_CYC - 1) &&
                    cnt_reg >= CNT_W'(SOP_CYC - 1) &&
                    cnt_reg >= CNT_W'(SWRD_CYC - 1)) begin
                    cnt_next   = '0;
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            cur_reg   <= '0;
            pins_reg  <= '{array_sel_n: 1'b1, flag_select_n: 1'b1,
                           write_n: 1'b1, out_en_n: 1'b1, addr: '0};
            dout_reg  <= '0;
            doe_reg   <= 1'b0;
            ready_reg <= 1'b0;
            rspv_reg  <= 1'b0;
            rspd_reg  <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cur_reg   <= cur_next;
            pins_reg  <= pins_next;
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            ready_reg <= ready_next;
            rspv_reg  <= rspv_next;
            rspd_reg  <= rspd_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The device arbitrates contended flags; a lost flag reads back as 1.
    assign pins_o      = pins_reg;
    assign data_o      = dout_reg;
    assign data_oe_o   = doe_reg;
    assign req_ready_o = ready_reg;
    assign rsp_valid_o = rspv_reg;
    assign rsp_data_o  = rspd_reg;

endmodule

/* File: verification/dps_ctrl_asserts.sv */
// Checker for the host-side port controller pins.
// Assumes it is bound to dps_ctrl and sees only its ports.
`timescale 1ns/1ns
module dps_ctrl_asserts
    import dps_pkg::*;
(
    input logic              mclk_i,
    input logic              rst_n_i,
    input dps_pins_t         pins_o,
    input logic [DATA_W-1:0] data_o,
    input logic              data_oe_o,
    input logic              rsp_valid_o
);
    wire cs  = pins_o.array_sel_n;
    wire fs  = pins_o.flag_select_n;
    wire wn  = pins_o.write_n;
    wire oen = pins_o.out_en_n;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // Properties
    // ----
    AST_ADDR_MOVE: assert property (
        $changed(pins_o.addr) |-> wn && $past(wn))
        else $error("address moved during a write");
    AST_SEL_HOLD: assert property (
        !wn && !$past(wn) |-> $stable({cs, fs}))
        else $error("selection changed inside the write window");
    AST_NO_FIGHT: assert property (data_oe_o |-> oen && $past(oen))
        else $error("host drives data while reads may be driven");
    AST_PULSE: assert property ($fell(wn) |-> !wn [*3] ##1 wn)
        else $error("write pulse not three cycles");
    AST_FLAG_CS: assert property (!fs |-> cs)
        else $error("array select low during a flag access");
    AST_WR_RD_GAP: assert property ($rose(wn) |-> oen [*2])
        else $error("read-back started too soon after a write");
    AST_FLAG_GAP: assert property ($rose(fs) |=> fs)
        else $error("flag select released for under one cycle");
    AST_HOLD: assert property (
        $rose(wn) |-> data_oe_o && $stable(data_o))
        else $error("write data not held after end of write");
    AST_RD_ANS: assert property ($fell(oen) |-> ##4 rsp_valid_o)
        else $error("read answer not four cycles after output enable");
    COV_MEM_WR: cover property ($fell(wn) && !cs);
    COV_FLAG_WR: cover property ($fell(wn) && !fs);
    COV_FLAG_RD: cover property ($fell(oen) && !fs);
    COV_MEM_RD: cover property ($fell(oen) && !cs);
endmodule
bind dps_ctrl dps_ctrl_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .rsp_valid_o(rsp_valid_o));

/* File: verification/dps_sram_model.sv */
// Behavioural model of one device port: byte array and eight flags.
// Assumes the bench resolves the shared data lines from drv_o.
`timescale 1ns/1ns
module dps_sram_model
    import dps_pkg::*;
(
    // Device pins
    input  dps_pins_t         pins_i,
    input  logic [DATA_W-1:0] d_i,
    // Read data and its drive enable
    output logic [DATA_W-1:0] q_o,
    output logic              drv_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0]        flag = 8'hFF;
    logic              wz   = 1'b0;
    wire cs = pins_i.array_sel_n;
    wire fs = pins_i.flag_select_n;
    // One port only, so every claim is granted to it alone.
    always @(posedge pins_i.write_n) begin
        if (!cs && fs) mem[pins_i.addr] = d_i;
        if (cs && !fs) flag[pins_i.addr[2:0]] = d_i[0];
    end
    always @(negedge (cs & fs)) wz = !pins_i.write_n;
    always @(posedge (cs & fs)) wz = 1'b0;
    assign drv_o = !pins_i.out_en_n && pins_i.write_n && !wz
                   && (cs ^ fs);
    assign q_o = !cs ? mem[pins_i.addr]
                     : {8{flag[pins_i.addr[2:0]]}};
endmodule

/* File: verification/test_dual_port_sram_port_access.sv */
// Self-checking bench for the port controller against a device model.
// Assumes the checker is bound in and the clock runs at 100 MHz.
`timescale 1ns/1ns
module test_dual_port_sram_port_access;
    import dps_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0;
    dps_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, data_oe_o, drv;
    logic [DATA_W-1:0] rsp_data_o, data_o, q, bus;
    dps_pins_t pins_o;
    int errors = 0, samples_checked = 0;
    always #5 mclk_i = ~mclk_i;
    // Released lines show a toggling pattern, never the last value.
    assign bus = data_oe_o ? data_o : drv ? q : 8'h5A ^ {8{mclk_i}};
    dps_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(bus));
    dps_sram_model u_dev (.pins_i(pins_o), .d_i(bus), .q_o(q), .drv_o(drv));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input dps_cmd_t c, input logic [16:0] a,
                         input logic [7:0] d);
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= '{cmd: c, addr: a, wdata: d};
        do @(posedge mclk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
    endtask
    task automatic rd(input dps_cmd_t c, input logic [16:0] a,
                      input logic [7:0] exp);
        issue(c, a, 8'h00);
        repeat (12) begin
            @(posedge mclk_i);
            if (rsp_valid_o === 1'b1) break;
        end
        chk({rsp_valid_o, 7'h00}, 8'h80);
        chk(rsp_data_o, exp);
    endtask
    task automatic t_mem;
        issue(CMD_MEM_WR, 17'h00000, 8'hA5);
        issue(CMD_MEM_WR, 17'h1FFFF, 8'h3C);
        issue(CMD_MEM_WR, 17'h00003, 8'hC3);
        rd(CMD_MEM_RD, 17'h1FFFF, 8'h3C);
        rd(CMD_MEM_RD, 17'h00000, 8'hA5);
    endtask
    task automatic t_flag;
        issue(CMD_SEM_WR, 17'h00003, 8'hFE);
        rd(CMD_SEM_RD, 17'h00003, 8'h00);
        rd(CMD_SEM_RD, 17'h00002, 8'hFF);
        rd(CMD_MEM_RD, 17'h00003, 8'hC3);
        issue(CMD_SEM_WR, 17'h00003, 8'h01);
        rd(CMD_SEM_RD, 17'h00003, 8'hFF);
    endtask
    task automatic summarize;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_mem();
        t_flag();
        summarize();
    end
    // Whole run needs about 90 cycles; the limit leaves wide margin.
    initial begin
        repeat (3000) @(posedge mclk_i);
        errors++;
        summarize();
    end
endmodule
